// File: rtl/fcl_cache_ctrl.v
// Four-way cache tag/LRU store with control, lock and fill sequencing
`timescale 1ns/1ps
`include "fcl_consts.vh"

module fcl_cache_ctrl (
    // Clock and resets
    input wire clk_i,
    input wire rst_i,
    input wire man_rst_i,
    // Wishbone slave
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // CPU state
    input wire [31:0] cpu_status_reg_i,
    // Access port
    input wire acc_req_i,
    input wire acc_prefetch_i,
    input wire acc_write_i,
    input wire [1:0] acc_area_i,
    input wire [7:0] acc_index_i,
    input wire [31:0] acc_paddr_i,
    input wire [31:0] acc_wdata_i,
    output reg acc_done_o,
    output reg acc_hit_o,
    output reg [1:0] acc_way_o,
    output reg acc_cached_o,
    output reg acc_wthru_o,
    output reg [31:0] acc_rdata_o,
    // Line fill port
    output reg fill_req_o,
    output reg [31:0] fill_addr_o,
    input wire fill_ack_i,
    input wire [127:0] fill_data_i,
    // Status
    output reg busy_o
);

    localparam ST_IDLE = 3'd0;
    localparam ST_LOOK = 3'd1;
    localparam ST_FILL = 3'd2;
    localparam ST_HOLD = 3'd3;
    localparam ST_SWEEP = 3'd4;

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Tag, valid, dirty and data arrays are indexed {way, set}; LRU by set
    reg [21:0] tag_mem [0:1023];
    reg valid_mem [0:1023];
    reg dirty_mem [0:1023];
    reg [127:0] data_mem [0:1023];
    reg [5:0] lru_mem [0:255];

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Make way w the newest in the pairwise age code
    function [5:0] lru_touch;
        input [5:0] c;
        input [1:0] w;
        begin
            case (w)
                2'd0: lru_touch = {3'b000, c[2:0]};
                2'd1: lru_touch = {1'b1, c[4:3], 2'b00, c[0]};
                2'd2: lru_touch = {c[5], 1'b1, c[3], 1'b1, c[1], 1'b0};
                default: lru_touch = {c[5:4], 1'b1, c[2], 2'b11};
            endcase
        end
    endfunction

    // lk[1] is way-3 lock, lk[0] is way-2 lock
    function [1:0] victim_map;
        input [1:0] lk;
        input [5:0] c;
        begin
            victim_map = 2'd0;
            case (lk)
                2'b00: begin
                    case (c)
                        6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34: victim_map = 2'd3;
                        6'h01, 6'h03, 6'h0b, 6'h21, 6'h29, 6'h2b: victim_map = 2'd2;
                        6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f: victim_map = 2'd1;
                        default: victim_map = 2'd0;
                    endcase
                end
                2'b01: begin
                    case (c)
                        6'h00, 6'h01, 6'h04, 6'h14, 6'h20, 6'h21, 6'h30, 6'h34: begin
                            victim_map = 2'd3;
                        end
                        6'h03, 6'h06, 6'h07, 6'h0b, 6'h0f, 6'h16, 6'h1e, 6'h1f: begin
                            victim_map = 2'd1;
                        end
                        default: victim_map = 2'd0;
                    endcase
                end
                2'b10: begin
                    case (c)
                        6'h00, 6'h01, 6'h03, 6'h0b, 6'h20, 6'h21, 6'h29, 6'h2b: begin
                            victim_map = 2'd2;
                        end
                        6'h04, 6'h06, 6'h07, 6'h0f, 6'h14, 6'h16, 6'h1e, 6'h1f: begin
                            victim_map = 2'd1;
                        end
                        default: victim_map = 2'd0;
                    endcase
                end
                default: begin
                    victim_map = c[5] ? 2'd0 : 2'd1;
                end
            endcase
        end
    endfunction

    function [31:0] get_word;
        input [127:0] line;
        input [1:0] sel;
        begin
            get_word = line[{sel, 5'b00000} +: 32];
        end
    endfunction

    function [127:0] put_word;
        input [127:0] line;
        input [1:0] sel;
        input [31:0] w;
        begin
            put_word = line;
            put_word[{sel, 5'b00000} +: 32] = w;
        end
    endfunction

    // ****************************************************************
    // Control and lock registers
    // ****************************************************************
    reg cache_on;
    reg write_through_sel;
    reg seg_one_write_policy;
    reg way2_lock;
    reg way2_load;
    reg way3_lock;
    reg way3_load;
    reg flush_req;

    wire wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire hit_ctl = (wb_adr_i == `FCL_ADR_CONTROL);
    wire hit_lock = (wb_adr_i == `FCL_ADR_LOCK);

    always @(posedge clk_i) begin
        if (rst_i || man_rst_i) begin
            cache_on <= 1'b0;
            write_through_sel <= 1'b0;
            seg_one_write_policy <= 1'b0;
            {way3_load, way3_lock, way2_load, way2_lock} <= `FCL_LOCK_RESET;
            flush_req <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_go;
            flush_req <= 1'b0;
            wb_dat_o <= 32'h00000000;
            if (wb_go && wb_we_i) begin
                if (hit_ctl && wb_sel_i[0]) begin
                    cache_on <= wb_dat_i[`FCL_CACHE_ON_BIT];
                    write_through_sel <= wb_dat_i[`FCL_WRITE_THROUGH_BIT];
                    seg_one_write_policy <= wb_dat_i[`FCL_SEG_ONE_POLICY_BIT];
                    flush_req <= wb_dat_i[`FCL_FLUSH_ALL_BIT];
                end
                if (hit_lock && wb_sel_i[0]) begin
                    way2_lock <= wb_dat_i[`FCL_WAY2_LOCK_BIT];
                    way2_load <= wb_dat_i[`FCL_WAY2_LOAD_BIT];
                end
                if (hit_lock && wb_sel_i[1]) begin
                    way3_lock <= wb_dat_i[`FCL_WAY3_LOCK_BIT];
                    way3_load <= wb_dat_i[`FCL_WAY3_LOAD_BIT];
                end
            end else if (wb_go && hit_ctl) begin
                // Flush bit and reserved bits always read as zero
                wb_dat_o[`FCL_CACHE_ON_BIT] <= cache_on;
                wb_dat_o[`FCL_WRITE_THROUGH_BIT] <= write_through_sel;
                wb_dat_o[`FCL_SEG_ONE_POLICY_BIT] <= seg_one_write_policy;
            end
        end
    end

    // ****************************************************************
    // Lookup
    // ****************************************************************
    reg [2:0] state;
    reg clear_pend;
    reg [7:0] sweep_idx;
    reg req_prefetch;
    reg req_write;
    reg [1:0] req_area;
    reg [7:0] req_idx;
    reg [31:0] req_paddr;
    reg [31:0] req_wdata;
    reg [1:0] victim;

    // Shadow bits never reach a stored tag, so compare them as zero
    wire [21:0] cmp_tag = {`FCL_SHADOW_ZERO, req_paddr[28:10]};
    wire [5:0] set_lru = lru_mem[req_idx];
    wire lock_mode = cpu_status_reg_i[`FCL_LOCK_MODE_BIT];
    wire req_wthru = (req_area == `FCL_AREA_SEG_ONE) ? ~seg_one_write_policy
                                                     : write_through_sel;
    wire req_uncached = ~cache_on | (req_area == `FCL_AREA_SEG_TWO);

    reg [3:0] hit_vec;
    reg [1:0] hit_way;
    reg [1:0] pick_way;
    integer k;

    always @* begin
        hit_vec = 4'h0;
        hit_way = 2'd0;
        for (k = 0; k < 4; k = k + 1) begin
            hit_vec[k] = valid_mem[{k[1:0], req_idx}] &&
                         (tag_mem[{k[1:0], req_idx}] == cmp_tag);
            if (hit_vec[k]) begin
                hit_way = k[1:0];
            end
        end
    end

    always @* begin
        if (!lock_mode) begin
            pick_way = victim_map(2'b00, set_lru);
        end else if (req_prefetch && way2_lock && way2_load && !way3_load) begin
            pick_way = 2'd2;
        end else if (req_prefetch && way3_lock && way3_load && !way2_load) begin
            pick_way = 2'd3;
        end else begin
            pick_way = victim_map({way3_lock, way2_lock}, set_lru);
        end
    end

    // ****************************************************************
    // Sequencer and array updates
    // ****************************************************************
    // Arrays carry no reset: the sweep after power-on or flush-all clears their flags
    reg [127:0] fill_line;
    integer w;

    always @* begin
        fill_line = fill_data_i;
        if (req_write) begin
            fill_line = put_word(fill_data_i, req_paddr[3:2], req_wdata);
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            clear_pend <= 1'b1;
            sweep_idx <= 8'h00;
            acc_done_o <= 1'b0;
            acc_hit_o <= 1'b0;
            acc_way_o <= 2'd0;
            acc_cached_o <= 1'b0;
            acc_wthru_o <= 1'b0;
            acc_rdata_o <= 32'h00000000;
            fill_req_o <= 1'b0;
            fill_addr_o <= 32'h00000000;
            busy_o <= 1'b1;
            req_prefetch <= 1'b0;
            req_write <= 1'b0;
            req_area <= 2'd0;
            req_idx <= 8'h00;
            req_paddr <= 32'h00000000;
            req_wdata <= 32'h00000000;
            victim <= 2'd0;
        end else if (man_rst_i) begin
            // Manual reset keeps flags; an interrupted sweep restarts
            state <= ST_IDLE;
            clear_pend <= clear_pend | (state == ST_SWEEP);
            acc_done_o <= 1'b0;
            fill_req_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            acc_done_o <= 1'b0;
            if (flush_req) begin
                clear_pend <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    busy_o <= 1'b0;
                    if (clear_pend || flush_req) begin
                        clear_pend <= 1'b0;
                        sweep_idx <= 8'h00;
                        busy_o <= 1'b1;
                        state <= ST_SWEEP;
                    end else if (acc_req_i) begin
                        req_prefetch <= acc_prefetch_i;
                        req_write <= acc_write_i;
                        req_area <= acc_area_i;
                        req_idx <= acc_index_i;
                        req_paddr <= acc_paddr_i;
                        req_wdata <= acc_wdata_i;
                        busy_o <= 1'b1;
                        state <= ST_LOOK;
                    end
                end
                ST_LOOK: begin
                    acc_wthru_o <= req_wthru;
                    acc_way_o <= hit_way;
                    if (req_uncached) begin
                        acc_done_o <= 1'b1;
                        acc_hit_o <= 1'b0;
                        acc_cached_o <= 1'b0;
                        state <= ST_HOLD;
                    end else if (hit_vec != 4'h0) begin
                        lru_mem[req_idx] <= lru_touch(set_lru, hit_way);
                        if (req_write) begin
                            data_mem[{hit_way, req_idx}] <= put_word(
                                data_mem[{hit_way, req_idx}], req_paddr[3:2], req_wdata);
                            if (!req_wthru) begin
                                dirty_mem[{hit_way, req_idx}] <= 1'b1;
                            end
                        end else if (!req_prefetch) begin
                            acc_rdata_o <= get_word(data_mem[{hit_way, req_idx}],
                                                    req_paddr[3:2]);
                        end
                        // A prefetch hit changes nothing but the age code
                        acc_done_o <= 1'b1;
                        acc_hit_o <= 1'b1;
                        acc_cached_o <= 1'b1;
                        state <= ST_HOLD;
                    end else if (req_write && req_wthru) begin
                        // Write-through miss goes to memory only
                        acc_done_o <= 1'b1;
                        acc_hit_o <= 1'b0;
                        acc_cached_o <= 1'b1;
                        state <= ST_HOLD;
                    end else begin
                        victim <= pick_way;
                        fill_req_o <= 1'b1;
                        fill_addr_o <= {req_paddr[31:4], 4'h0};
                        state <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (fill_ack_i) begin
                        fill_req_o <= 1'b0;
                        tag_mem[{victim, req_idx}] <= cmp_tag;
                        valid_mem[{victim, req_idx}] <= 1'b1;
                        dirty_mem[{victim, req_idx}] <= req_write;
                        data_mem[{victim, req_idx}] <= fill_line;
                        lru_mem[req_idx] <= lru_touch(set_lru, victim);
                        if (!req_write && !req_prefetch) begin
                            acc_rdata_o <= get_word(fill_data_i, req_paddr[3:2]);
                        end
                        acc_done_o <= 1'b1;
                        acc_hit_o <= 1'b0;
                        acc_way_o <= victim;
                        acc_cached_o <= 1'b1;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Waits for the requester to drop its level request
                    if (!acc_req_i) begin
                        busy_o <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_SWEEP: begin
                    for (w = 0; w < 4; w = w + 1) begin
                        valid_mem[{w[1:0], sweep_idx}] <= 1'b0;
                        dirty_mem[{w[1:0], sweep_idx}] <= 1'b0;
                    end
                    lru_mem[sweep_idx] <= `FCL_LRU_RESET;
                    sweep_idx <= sweep_idx + 8'h01;
                    if (sweep_idx == `FCL_SWEEP_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: rtl/fcl_consts.vh
// Constants for the four-way cache control block
// Overview of operation
// - Four ways, 256 entries each, 16-byte lines
// - Tag is physical bits 28-10, compared on lookup
// - Normal fill writes zero into top three tag bits
// - Power-on clears valid/dirty; manual reset keeps them
// - Valid marks good data; dirty marks write-back writes
// - Set index is address bits 11-4
// - Per-set 6-bit LRU, power-on clears to zero
// - Unlocked victim decoded from 24-pattern map
// - Cache-on bit enables cache; zero bypasses it
// - Flush-all clears valid, dirty, LRU; reads zero
// - Segment-one policy bit: 1 write-back, 0 write-through
// - Write-through bit governs segments zero and three
// - Lock register acts only when status bit 12 set
// - Lock register write-only, fields at 9,8,1,0
// - Prefetch hit fetches nothing, keeps entry
// - Prefetch miss with lock and load, other way's load clear, fills that way
// - Other lock-mode misses use lock-bit selected map
// - Way-2-locked map never picks way 2
// - Way-3-locked map never picks way 3
// - Both locked: LRU bit 5 picks way 0 or 1
// - Read-miss fill sets valid, clears dirty
`ifndef FCL_CONSTS_VH
`define FCL_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define FCL_ADR_CONTROL 32'hffffffec
`define FCL_ADR_LOCK 32'h040000b0
`define FCL_CONTROL_RESET 3'h0
`define FCL_LOCK_RESET 4'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define FCL_CACHE_ON_BIT 0
`define FCL_WRITE_THROUGH_BIT 1
`define FCL_SEG_ONE_POLICY_BIT 2
`define FCL_FLUSH_ALL_BIT 3
`define FCL_WAY2_LOCK_BIT 0
`define FCL_WAY2_LOAD_BIT 1
`define FCL_WAY3_LOCK_BIT 8
`define FCL_WAY3_LOAD_BIT 9
`define FCL_LOCK_MODE_BIT 12

// ****************************************************************
// Address areas seen on the access port
// ****************************************************************
`define FCL_AREA_SEG_ZERO 2'h0
`define FCL_AREA_SEG_ONE 2'h1
`define FCL_AREA_SEG_TWO 2'h2
`define FCL_AREA_SEG_THREE 2'h3

// ****************************************************************
// Array values
// ****************************************************************
`define FCL_LRU_RESET 6'h00
`define FCL_SHADOW_ZERO 3'h0
`define FCL_SWEEP_LAST 8'hff

`endif

// File: tb/fcl_cache_ctrl_assertions.sv
// Checker for the cache control block
`timescale 1ns/1ps
`include "fcl_consts.vh"
module fcl_cache_ctrl_assertions (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic man_rst_i,
    // Register bus
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Access and fill
    input wire logic [31:0] cpu_status_reg_i,
    input wire logic acc_prefetch_i,
    input wire logic acc_write_i,
    input wire logic [1:0] acc_area_i,
    input wire logic acc_done_o,
    input wire logic acc_hit_o,
    input wire logic [1:0] acc_way_o,
    input wire logic acc_cached_o,
    input wire logic acc_wthru_o,
    input wire logic fill_req_o,
    input wire logic [31:0] fill_addr_o,
    input wire logic fill_ack_i,
    input wire logic busy_o
);
    logic ce, wt, cb, lk2, ld2, lk3, ld3;
    wire wr_take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    wire miss = acc_done_o && acc_cached_o && !acc_hit_o && !acc_write_i;
    wire lock_on = cpu_status_reg_i[`FCL_LOCK_MODE_BIT];
    wire rd_ack = wb_ack_o && !wb_we_i;
    // Shadow of the writable fields, same edge as the design
    always @(posedge clk_i) begin
        if (rst_i || man_rst_i) begin
            {ce, wt, cb, lk2, ld2, lk3, ld3} <= 7'h00;
        end else if (wr_take && wb_adr_i == `FCL_ADR_CONTROL && wb_sel_i[0]) begin
            {cb, wt, ce} <= wb_dat_i[2:0];
        end else if (wr_take && wb_adr_i == `FCL_ADR_LOCK) begin
            if (wb_sel_i[0]) {ld2, lk2} <= wb_dat_i[1:0];
            if (wb_sel_i[1]) {ld3, lk3} <= wb_dat_i[9:8];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || man_rst_i);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("late ack");
    AST_CTRL_READ: assert property (rd_ack && wb_adr_i == `FCL_ADR_CONTROL
        |-> wb_dat_o == {29'h0, cb, wt, ce}) else $error("bad control read");
    AST_LOCK_READ: assert property (rd_ack && wb_adr_i == `FCL_ADR_LOCK
        |-> wb_dat_o == 32'h0) else $error("lock read not zero");
    AST_FILL_ALIGN: assert property (fill_req_o |-> fill_addr_o[3:0] == 4'h0)
        else $error("fill addr unaligned");
    AST_FILL_HOLD: assert property (fill_req_o && !fill_ack_i
        |=> fill_req_o && $stable(fill_addr_o)) else $error("fill req dropped");
    AST_FILL_DONE: assert property (fill_req_o && fill_ack_i
        |=> acc_done_o && acc_cached_o) else $error("fill not finished");
    AST_BYPASS: assert property (acc_done_o && (!ce || acc_area_i == `FCL_AREA_SEG_TWO)
        |-> !acc_cached_o && !acc_hit_o) else $error("bypass used cache");
    AST_WTHRU: assert property (acc_done_o && acc_cached_o
        |-> acc_wthru_o == (acc_area_i == `FCL_AREA_SEG_ONE ? !cb : wt))
        else $error("bad write policy");
    AST_LOCK2: assert property (miss && lock_on && lk2 && !lk3 && !acc_prefetch_i
        |-> acc_way_o != 2'h2) else $error("locked way 2 replaced");
    AST_LOCK3: assert property (miss && lock_on && lk3 && !lk2 && !acc_prefetch_i
        |-> acc_way_o != 2'h3) else $error("locked way 3 replaced");
    AST_BOTH: assert property (miss && lock_on && lk2 && lk3 && !acc_prefetch_i
        |-> !acc_way_o[1]) else $error("upper way replaced");
    AST_PREFETCH_INSTRUCTION_LOAD: assert property (miss && acc_prefetch_i && lock_on && (ld2 ^ ld3)
        && (ld2 ? lk2 : lk3) |-> acc_way_o == (ld2 ? 2'h2 : 2'h3)) else $error("bad prefetch way");
    AST_SWEEP: assert property ($fell(rst_i) |-> busy_o [*8])
        else $error("no sweep after reset");
endmodule

bind fcl_cache_ctrl fcl_cache_ctrl_assertions u_chk (.*);

// File: tb/fcl_mem_model.sv
// Line-fill memory model answering the cache's fill requests
`timescale 1ns/1ps
module fcl_mem_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill handshake
    input wire logic fill_req_i,
    input wire logic [31:0] fill_addr_i,
    input wire logic [3:0] delay_i,
    output logic fill_ack_o,
    output logic [127:0] fill_data_o
);
    logic [3:0] wait_cnt;
    // Data toggles outside the answer so a late sample fails
    always @(posedge clk_i) begin
        fill_ack_o <= 1'b0;
        fill_data_o <= ~fill_data_o;
        if (rst_i) begin
            wait_cnt <= 4'h0;
            fill_data_o <= 128'h0;
        end else if (fill_req_i && !fill_ack_o) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt >= delay_i) begin
                fill_ack_o <= 1'b1;
                wait_cnt <= 4'h0;
                for (int n = 0; n < 4; n++) fill_data_o[32*n +: 32] <= fill_addr_i | 32'(n);
            end
        end
    end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the cache control block
`timescale 1ns/1ps
`include "fcl_consts.vh"
module tb_top;
    typedef struct packed {
        logic [3:0] ctl;
        logic [3:0] lck;
        logic [2:0] spw;
        logic [1:0] ar;
        logic [7:0] ix;
        logic hit;
        logic [1:0] way;
        logic [1:0] cw;
    } fcl_row_t;
    logic clk_i, rst_i, man_rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, cpu_status_reg_i, acc_paddr_i, acc_wdata_i;
    logic [3:0] wb_sel_i, dly;
    logic acc_req_i, acc_prefetch_i, acc_write_i, acc_done_o, acc_hit_o, acc_cached_o;
    logic acc_wthru_o, fill_req_o, fill_ack_i, busy_o;
    logic [1:0] acc_area_i, acc_way_o;
    logic [7:0] acc_index_i;
    logic [31:0] acc_rdata_o, fill_addr_o, rd;
    logic [127:0] fill_data_i;
    fcl_row_t rows [15];
    fcl_row_t r;
    int failures = 0;
    int comparisons = 0;
    fcl_cache_ctrl DUT (
        .clk_i(clk_i), .rst_i(rst_i), .man_rst_i(man_rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cpu_status_reg_i(cpu_status_reg_i), .acc_req_i(acc_req_i),
        .acc_prefetch_i(acc_prefetch_i), .acc_write_i(acc_write_i), .acc_area_i(acc_area_i),
        .acc_index_i(acc_index_i), .acc_paddr_i(acc_paddr_i), .acc_wdata_i(acc_wdata_i),
        .acc_done_o(acc_done_o), .acc_hit_o(acc_hit_o), .acc_way_o(acc_way_o),
        .acc_cached_o(acc_cached_o), .acc_wthru_o(acc_wthru_o), .acc_rdata_o(acc_rdata_o),
        .fill_req_o(fill_req_o), .fill_addr_o(fill_addr_o), .fill_ack_i(fill_ack_i),
        .fill_data_i(fill_data_i), .busy_o(busy_o)
    );
    fcl_mem_model u_mem (
        .clk_i(clk_i), .rst_i(rst_i), .fill_req_i(fill_req_o), .fill_addr_i(fill_addr_o),
        .delay_i(dly), .fill_ack_o(fill_ack_i), .fill_data_o(fill_data_i)
    );
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("FAIL %0t got %h exp %h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic finish_test;
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        wb_adr_i <= adr;
        wb_we_i <= we;
        wb_dat_i <= dat;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Write data equals the fill pattern, so later reads stay valid
    task automatic acc(input logic [2:0] spw, input logic [1:0] ar, input logic [7:0] ix,
                       input logic [7:0] tg);
        cpu_status_reg_i <= {19'h0, spw[2], 12'h0};
        acc_prefetch_i <= spw[1];
        acc_write_i <= spw[0];
        acc_area_i <= ar;
        acc_index_i <= ix;
        acc_paddr_i <= {12'h0, tg, ix, 4'h8};
        acc_wdata_i <= {12'h0, tg, ix, 4'h2};
        acc_req_i <= 1'b1;
        do @(posedge clk_i); while (acc_done_o !== 1'b1);
        acc_req_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    initial begin
        #100000;
        failures++;
        finish_test();
    end
    initial begin
        {rst_i, wb_sel_i, dly} = {1'b1, 4'hf, 4'h0};
        {man_rst_i, wb_we_i, wb_cyc_i, wb_stb_i, acc_req_i} = 5'h0;
        {acc_prefetch_i, acc_write_i, acc_area_i, acc_index_i} = 12'h0;
        {wb_adr_i, wb_dat_i, cpu_status_reg_i, acc_paddr_i, acc_wdata_i} = 160'h0;
        // ctl, lock, {mode,prefetch_instruction,wr}, area, set, hit, way, {cached,wthru}
        rows[0] = {4'h1, 4'h0, 3'h0, 2'h0, 8'h01, 1'b0, 2'h3, 2'h2};
        rows[1] = {4'h1, 4'h0, 3'h0, 2'h0, 8'h01, 1'b1, 2'h3, 2'h2};
        rows[2] = {4'h1, 4'h1, 3'h4, 2'h0, 8'h02, 1'b0, 2'h3, 2'h2};
        rows[3] = {4'h1, 4'h4, 3'h4, 2'h0, 8'h03, 1'b0, 2'h2, 2'h2};
        rows[4] = {4'h1, 4'h5, 3'h4, 2'h0, 8'h04, 1'b0, 2'h1, 2'h2};
        rows[5] = {4'h1, 4'h3, 3'h6, 2'h0, 8'h05, 1'b0, 2'h2, 2'h2};
        rows[6] = {4'h1, 4'hc, 3'h6, 2'h0, 8'h06, 1'b0, 2'h3, 2'h2};
        rows[7] = {4'h1, 4'hc, 3'h6, 2'h0, 8'h05, 1'b1, 2'h2, 2'h2};
        rows[8] = {4'h1, 4'h4, 3'h0, 2'h0, 8'h07, 1'b0, 2'h3, 2'h2};
        rows[9] = {4'h0, 4'h0, 3'h0, 2'h0, 8'h08, 1'b0, 2'h0, 2'h0};
        rows[10] = {4'h5, 4'h0, 3'h0, 2'h1, 8'h01, 1'b1, 2'h3, 2'h2};
        rows[11] = {4'h1, 4'h0, 3'h0, 2'h1, 8'h01, 1'b1, 2'h3, 2'h3};
        rows[12] = {4'h3, 4'h0, 3'h0, 2'h3, 8'h01, 1'b1, 2'h3, 2'h3};
        rows[13] = {4'h3, 4'h0, 3'h1, 2'h0, 8'h01, 1'b1, 2'h3, 2'h3};
        rows[14] = {4'h1, 4'h0, 3'h0, 2'h2, 8'h09, 1'b0, 2'h0, 2'h0};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            r = rows[i];
            dly <= 4'(i % 4 * 3);
            wb(1'b1, `FCL_ADR_CONTROL, {28'h0, r.ctl});
            wb(1'b1, `FCL_ADR_LOCK, {22'h0, r.lck[3:2], 6'h0, r.lck[1:0]});
            acc(r.spw, r.ar, r.ix, 8'h5a);
            chk(32'(acc_cached_o), 32'(r.cw[1]));
            chk(32'(acc_hit_o), 32'(r.hit));
            if (r.cw[1]) chk(32'(acc_wthru_o), 32'(r.cw[0]));
            if (r.cw[1]) chk(32'(acc_way_o), 32'(r.way));
            if (r.cw[1] && r.spw[1:0] == 2'h0) chk(acc_rdata_o, {12'h0, 8'h5a, r.ix, 4'h2});
        end
        acc(3'h0, 2'h0, 8'h01, 8'h3c);
        chk(32'(acc_hit_o), 32'h0);
        wb(1'b1, `FCL_ADR_CONTROL, 32'h0000000f);
        wb(1'b0, `FCL_ADR_CONTROL, 32'h0);
        chk(rd, 32'h00000007);
        wb(1'b0, `FCL_ADR_LOCK, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 32'h00000100, 32'h0);
        chk(rd, 32'h0);
        acc(3'h0, 2'h0, 8'h01, 8'h5a);
        chk(32'(acc_hit_o), 32'h0);
        chk(32'(acc_way_o), 32'h3);
        man_rst_i <= 1'b1;
        @(posedge clk_i);
        man_rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `FCL_ADR_CONTROL, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, `FCL_ADR_CONTROL, 32'h1);
        acc(3'h0, 2'h0, 8'h01, 8'h5a);
        chk(32'(acc_hit_o), 32'h1);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, `FCL_ADR_CONTROL, 32'h1);
        acc(3'h0, 2'h0, 8'h01, 8'h5a);
        chk(32'(acc_hit_o), 32'h0);
        finish_test();
    end
endmodule
